// ==== hdl/adcflt_top.sv ====
// Purpose: Two-channel sinc3/sinc1 decimator, DC block, test mux, phase cal
// Assumes: Modulator bits are async pins; modulator clock made here
// Notes:   APB slave with one wait state; pready, prdata, pslverr registered
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module adcflt_top
   import adcflt_pkg::*;
#(
   parameter int HALF_DIV = adcflt_pkg::MOD_HALF_DIV
)
(
   input  wire logic                        clk_sys,
   input  wire logic                        srst,
   input  wire logic [adcflt_pkg::ADDR_W-1:0] paddr,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [31:0]                 pwdata,
   input  wire logic [3:0]                  pstrb,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic [adcflt_pkg::NCH-1:0]  mod_bit_in,
   output logic                             modulator_clk,
   output logic                             conv_ready_n
);
   import adcflt_pkg::*;

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
            r[8*b +: 8] = new_v[8*b +: 8];
      end
      return r;
   endfunction : merge

   function automatic logic signed [DATA_W-1:0] sat24(
      input logic signed [CIC_W+HP_FRAC:0] v);
      logic signed [CIC_W+HP_FRAC:0] hi;
      logic signed [CIC_W+HP_FRAC:0] lo;
      hi = (CIC_W+HP_FRAC+1)'(2**(DATA_W-1) - 1);
      lo = -(CIC_W+HP_FRAC+1)'(2**(DATA_W-1));
      if (v > hi)
         return {1'b0, {(DATA_W-1){1'b1}}};
      else if (v < lo)
         return {1'b1, {(DATA_W-1){1'b0}}};
      return v[DATA_W-1:0];
   endfunction : sat24

   logic [31:0]               ctrl_q;
   logic [31:0]               cfg_q    [NCH];
   logic [NCH-1:0]            sync1_q;
   logic [NCH-1:0]            sync2_q;
   logic [$clog2(HALF_DIV)-1:0] div_q;
   logic                      tick;
   logic                      mclk_q;
   logic [4:0]                tst_acc_q;
   logic                      tst_bit_q;
   logic [CNT_W-1:0]          gcnt_q;
   logic [3:0]                osr_code;
   logic [3:0]                s3_code;
   logic [HPC_W-1:0]          hp_corner_sel;
   logic [CNT_W-1:0]          mask_all;
   logic [CNT_W-1:0]          mask_s3;
   logic [4:0]                norm_sh;
   logic [2:0]                sinc1_sh;
   logic signed [PH_W:0]      ph_lim;
   logic signed [PH_W:0]      ph_hi;
   logic signed [PH_W-1:0]    eff_ph   [NCH];
   logic signed [DATA_W-1:0]  res_q    [NCH];
   logic signed [DATA_W-1:0]  out_q    [NCH];
   logic [NCH-1:0]            done_q;
   logic [NCH-1:0]            pend_q;
   logic                      all_pend;
   logic                      lag_ch;
   logic [7:0]                set_cnt_q;
   logic                      acc_phase;
   logic                      wr_en;
   logic                      rd_data1;

   // Clamp OSR code and derive per-stage decimation
   assign osr_code  = (ctrl_q[CTRL_OSR_LSB +: OSR_W] > OSR_CODE_MAX) ?
                      OSR_CODE_MAX : ctrl_q[CTRL_OSR_LSB +: OSR_W];
   assign s3_code   = (osr_code > OSR_S3_MAX) ? OSR_S3_MAX : osr_code;
   assign hp_corner_sel = ctrl_q[CTRL_HPC_LSB +: HPC_W];
   assign mask_all  = CNT_W'((32'd1 << (OSR_MIN_LOG2 + int'(osr_code))) - 1);
   assign mask_s3   = CNT_W'((32'd1 << (OSR_MIN_LOG2 + int'(s3_code))) - 1);
   assign norm_sh   = 5'(CIC_NORM - 3*(OSR_MIN_LOG2 + int'(s3_code)));
   assign sinc1_sh  = 3'(osr_code - s3_code);
   assign ph_lim    = (osr_code >= OSR_S3_MAX) ? (PH_W+1)'(2**(PH_W-1)) :
                      (PH_W+1)'((32'd1 << (OSR_MIN_LOG2 + int'(osr_code))) >> 1);
   assign ph_hi     = ph_lim - $signed((PH_W+1)'(1));

   // APB: access completes on the second cycle of the access phase
   assign acc_phase = psel && penable && !pready;
   assign wr_en     = psel && penable && pready && pwrite;
   assign rd_data1  = psel && penable && pready && !pwrite &&
                      (paddr == OFS_CH1_DATA);

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= acc_phase;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (acc_phase)
         begin
            unique case (paddr)
               OFS_CTRL:      prdata <= ctrl_q;
               OFS_CH0_CFG:   prdata <= cfg_q[0];
               OFS_CH1_CFG:   prdata <= cfg_q[1];
               OFS_CH0_DATA:  prdata <= 32'(out_q[0]);
               OFS_CH1_DATA:  prdata <= 32'(out_q[1]);
               OFS_STATUS:    prdata <= {16'h0000, set_cnt_q,
                                         7'h00, !conv_ready_n};
               OFS_EFF_PHASE: prdata <= {6'h00, eff_ph[1], 6'h00, eff_ph[0]};
               default:       pslverr <= 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         ctrl_q <= CTRL_RST;
      else if (wr_en && paddr == OFS_CTRL)
         ctrl_q <= merge(ctrl_q, pwdata, pstrb);
   end

   // Pin sync and modulator clock; tick marks one modulator cycle
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= mod_bit_in;
         sync2_q <= sync1_q;
      end
   end

   assign tick = mclk_q && (div_q == '0);

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         div_q  <= '0;
         mclk_q <= 1'b0;
      end
      else
      begin
         div_q <= (div_q == ($clog2(HALF_DIV))'(HALF_DIV - 1)) ?
                  '0 : div_q + 1'b1;
         if (div_q == '0)
            mclk_q <= !mclk_q;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         modulator_clk <= 1'b0;
      else
         modulator_clk <= mclk_q;
   end

   // Shared test stream, first-order, one for all channels
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         tst_acc_q <= '0;
         tst_bit_q <= 1'b0;
      end
      else if (tick)
      begin
         // Sum can pass 31, so the compare needs a sixth bit
         if (6'(tst_acc_q) + 6'(TST_STEP) >= 6'(TST_MOD))
         begin
            tst_acc_q <= tst_acc_q + TST_STEP - TST_MOD;
            tst_bit_q <= 1'b1;
         end
         else
         begin
            tst_acc_q <= tst_acc_q + TST_STEP;
            tst_bit_q <= 1'b0;
         end
      end
   end

   // Common window reference; restarts on any write to the control register
   always_ff @(posedge clk_sys)
   begin
      if (srst || (wr_en && paddr == OFS_CTRL))
         gcnt_q <= '0;
      else if (tick)
         gcnt_q <= (gcnt_q + 1'b1) & mask_all;
   end

   for (genvar c = 0; c < NCH; c++)
   begin : g_ch
      logic signed [PH_W:0]      ph_raw;
      logic [CNT_W-1:0]          lcnt;
      logic                      s3_tick;
      logic                      wend;
      logic                      bit_sel;
      adcflt_insel_t             sel;
      logic signed [CIC_W-1:0]   x;
      logic signed [CIC_W-1:0]   i1_q, i2_q, i3_q, d1_q, d2_q, d3_q;
      logic signed [CIC_W-1:0]   c1, c2, c3;
      logic signed [CIC_W-1:0]   s3n;
      logic signed [DATA_W-1:0]  v24;
      logic signed [ACC1_W-1:0]  acc1_q;
      logic signed [ACC1_W-1:0]  acc1_n;
      logic signed [DATA_W-1:0]  xd;
      logic signed [CIC_W+HP_FRAC:0] mean_q;
      logic signed [CIC_W+HP_FRAC:0] xw;
      logic                      hp_on;
      logic                      toggle_q;

      always_ff @(posedge clk_sys)
      begin
         if (srst)
            cfg_q[c] <= CFG_RST;
         else if (wr_en && paddr == (c == 0 ? OFS_CH0_CFG : OFS_CH1_CFG))
            cfg_q[c] <= merge(cfg_q[c], pwdata, pstrb);
      end

      // Saturate the programmed phase to the OSR range
      assign ph_raw = (PH_W+1)'($signed(cfg_q[c][CFG_PH_LSB +: PH_W]));
      assign eff_ph[c] = (ph_raw > ph_hi) ? PH_W'(ph_hi) :
                         (ph_raw < -ph_lim) ? PH_W'(-ph_lim) :
                         PH_W'(ph_raw);
      assign lcnt = (gcnt_q - CNT_W'(eff_ph[c])) & mask_all;
      assign s3_tick = tick && ((lcnt & mask_s3) == mask_s3);
      assign wend    = tick && (lcnt == mask_all);

      // Input selector
      assign sel = adcflt_insel_t'(cfg_q[c][CFG_SEL_LSB +: SEL_W]);
      always_comb
      begin
         unique case (sel)
            SEL_NORMAL:   bit_sel = sync2_q[c];
            SEL_SHORT:    bit_sel = toggle_q;
            SEL_TEST_POS: bit_sel = tst_bit_q;
            SEL_TEST_NEG: bit_sel = !tst_bit_q;
         endcase
      end
      assign x = bit_sel ? CIC_W'(1) : -CIC_W'(1);

      always_ff @(posedge clk_sys)
      begin
         if (srst)
            toggle_q <= 1'b0;
         else if (tick)
            toggle_q <= !toggle_q;
      end

      // Sinc3: modulo integrators, combs at the sinc3 rate
      assign c1 = i3_q - d1_q;
      assign c2 = c1 - d2_q;
      assign c3 = c2 - d3_q;
      always_ff @(posedge clk_sys)
      begin
         if (srst)
         begin
            i1_q <= '0; i2_q <= '0; i3_q <= '0;
            d1_q <= '0; d2_q <= '0; d3_q <= '0;
         end
         else if (tick)
         begin
            i1_q <= i1_q + x;
            i2_q <= i2_q + i1_q;
            i3_q <= i3_q + i2_q;
            if (s3_tick)
            begin
               d1_q <= i3_q;
               d2_q <= c1;
               d3_q <= c2;
            end
         end
      end

      // Full scale N^3 maps to 2^23 regardless of OSR
      assign s3n = c3 <<< norm_sh;
      assign v24 = sat24((CIC_W+HP_FRAC+1)'(s3n >>> FS_SHIFT));

      // Sinc1 over the remaining factor; pass-through at OSR <= 1024
      assign acc1_n = acc1_q + ACC1_W'(v24);
      always_ff @(posedge clk_sys)
      begin
         if (srst || wend)
            acc1_q <= '0;
         else if (s3_tick)
            acc1_q <= acc1_n;
      end
      assign xd = DATA_W'(acc1_n >>> sinc1_sh);

      // DC block: y = x - mean; mean += a*(x - mean), a = 2^-(code+1)
      assign hp_on = (hp_corner_sel != '0) &&
                     !cfg_q[c][CFG_DIS_BIT];
      assign xw = (CIC_W+HP_FRAC+1)'(xd) <<< HP_FRAC;
      always_ff @(posedge clk_sys)
      begin
         if (srst || !hp_on)
            mean_q <= '0;
         else if (wend)
            mean_q <= mean_q + ((xw - mean_q) >>>
                      (int'(hp_corner_sel) + 1));
      end

      always_ff @(posedge clk_sys)
      begin
         if (srst)
         begin
            res_q[c]  <= '0;
            done_q[c] <= 1'b0;
         end
         else
         begin
            done_q[c] <= wend;
            if (wend)
               res_q[c] <= hp_on ?
                  sat24((CIC_W+HP_FRAC+1)'(xd) -
                        (mean_q >>> HP_FRAC)) : xd;
         end
      end
   end

   // Set closes on the most delayed channel, so a positive phase delays ready
   assign lag_ch   = (eff_ph[1] > eff_ph[0]) ? 1'b1 : 1'b0;
   assign all_pend = &(pend_q | done_q) && done_q[lag_ch];

   always_ff @(posedge clk_sys)
   begin
      if (srst || all_pend)
         pend_q <= '0;
      else
         pend_q <= pend_q | done_q;
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         out_q[0]  <= '0;
         out_q[1]  <= '0;
         set_cnt_q <= '0;
      end
      else if (all_pend)
      begin
         out_q[0]  <= res_q[0];
         out_q[1]  <= res_q[1];
         set_cnt_q <= set_cnt_q + 1'b1;
      end
   end

   // Low once the set is complete; a read of channel 1 data releases it
   // Set beats the read-clear in the same cycle
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         conv_ready_n <= 1'b1;
      else if (all_pend)
         conv_ready_n <= 1'b0;
      else if (rd_data1)
         conv_ready_n <= 1'b1;
   end
endmodule : adcflt_top
`default_nettype wire

// ==== hdl/adcflt_pkg.sv ====
// Purpose: Shared constants for the two-channel decimation filter block
// Assumes: APB register access, 32-bit data, one aligned word per register
// Notes:   Field positions and reset values are used by the filter top
package adcflt_pkg;
   localparam int          NCH            = 2;
   localparam int          ADDR_W         = 8;
   // Register byte offsets
   localparam logic [7:0]  OFS_CTRL       = 8'h00;
   localparam logic [7:0]  OFS_CH0_CFG    = 8'h04;
   localparam logic [7:0]  OFS_CH1_CFG    = 8'h08;
   localparam logic [7:0]  OFS_CH0_DATA   = 8'h0c;
   localparam logic [7:0]  OFS_CH1_DATA   = 8'h10;
   localparam logic [7:0]  OFS_STATUS     = 8'h14;
   localparam logic [7:0]  OFS_EFF_PHASE  = 8'h18;
   // Control register fields
   localparam int          CTRL_OSR_LSB   = 0;
   localparam int          OSR_W          = 4;
   localparam int          CTRL_HPC_LSB   = 4;
   localparam int          HPC_W          = 4;
   localparam logic [31:0] CTRL_RST       = 32'h0000_0004;
   // Channel config fields
   localparam int          CFG_PH_LSB     = 0;
   localparam int          PH_W           = 10;
   localparam int          CFG_SEL_LSB    = 16;
   localparam int          SEL_W          = 2;
   localparam int          CFG_DIS_BIT    = 20;
   localparam logic [31:0] CFG_RST        = 32'h0000_0000;
   // Status / phase readback fields
   localparam int          STAT_CNT_LSB   = 8;
   localparam int          EFF_PH1_LSB    = 16;
   // OSR codes: code c gives OSR = 64 << c
   localparam logic [3:0]  OSR_CODE_MAX   = 4'h8;
   localparam logic [3:0]  OSR_S3_MAX     = 4'h4;
   localparam int          OSR_MIN_LOG2   = 6;
   localparam int          CNT_W          = 14;
   // Datapath
   localparam int          CIC_W          = 32;
   localparam int          CIC_NORM       = 30;
   localparam int          FS_SHIFT       = 7;
   localparam int          DATA_W         = 24;
   localparam int          HP_FRAC        = 16;
   localparam int          ACC1_W         = 28;
   // Test level 2/15 of full scale: ones density 17/30
   localparam logic [4:0]  TST_MOD        = 5'h1e;
   localparam logic [4:0]  TST_STEP       = 5'h11;
   localparam int          MOD_HALF_DIV   = 16;

   typedef enum logic [1:0]
   {
      SEL_NORMAL   = 2'h0,
      SEL_SHORT    = 2'h1,
      SEL_TEST_POS = 2'h2,
      SEL_TEST_NEG = 2'h3
   } adcflt_insel_t;
endpackage : adcflt_pkg

// ==== dv/acfp_checker.sv ====
// Purpose: Port checks for the two-channel filter block
// Assumes: APB master holds each request until pready
// Notes:   Modulator clock edges judged only after the first one
`timescale 1ns/10ps
`default_nettype none
module acfp_checker
   import adcflt_pkg::*;
#(
   parameter int HALF_DIV = 16
)
(
   input wire logic              clk_sys,
   input wire logic              srst,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [31:0]       pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic [NCH-1:0]    mod_bit_in,
   input wire logic              modulator_clk,
   input wire logic              conv_ready_n
);
   logic [2:0] rd_age_q;
   int         mclk_cnt_q;
   logic       mclk_seen_q;
   logic       mclk_prev_q;
   wire logic  rd_ch1 = psel && penable && pready && !pwrite
                        && paddr == OFS_CH1_DATA;
   wire logic  rd_dat = pready && !pwrite
                        && (paddr == OFS_CH0_DATA || paddr == OFS_CH1_DATA);
   wire logic  unmapped = paddr > OFS_EFF_PHASE || paddr[1:0] != 2'h0;

   // Cycles since the host last read the second channel's data
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         rd_age_q <= 3'h7;
      else if (rd_ch1)
         rd_age_q <= 3'h0;
      else if (rd_age_q != 3'h7)
         rd_age_q <= rd_age_q + 3'h1;
   end

   // First edge after reset skipped: divider phase is not fixed there
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         mclk_cnt_q  <= 0;
         mclk_seen_q <= 1'b0;
         mclk_prev_q <= 1'b0;
      end
      else
      begin
         mclk_prev_q <= modulator_clk;
         mclk_cnt_q  <= (modulator_clk != mclk_prev_q) ? 0 : mclk_cnt_q + 1;
         if (modulator_clk != mclk_prev_q)
            mclk_seen_q <= 1'b1;
      end
   end

   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && !pready;
   endsequence

   a_reset_quiet: assert property (@(posedge clk_sys)
      srst |=> conv_ready_n && !pready && !modulator_clk && prdata == 32'h0)
      else $error("outputs not idle after reset");
   a_access_ready: assert property (@(posedge clk_sys) disable iff (srst)
      s_setup ##1 s_access |=> pready)
      else $error("pready missing after access cycle");
   a_ready_pulse: assert property (@(posedge clk_sys) disable iff (srst)
      pready |=> !pready && !pslverr)
      else $error("pready longer than one cycle");
   a_ready_cause: assert property (@(posedge clk_sys) disable iff (srst)
      pready |-> $past(psel) && $past(penable) && psel)
      else $error("pready without access phase");
   a_err_decode: assert property (@(posedge clk_sys) disable iff (srst)
      pready |-> pslverr == unmapped && (!pslverr || prdata == 32'h0))
      else $error("slave error does not match address");
   a_idle_zero: assert property (@(posedge clk_sys) disable iff (srst)
      !pready |-> prdata == 32'h0 && !pslverr)
      else $error("read data outside transfer");
   a_data_signext: assert property (@(posedge clk_sys) disable iff (srst)
      rd_dat |-> prdata[31:24] == {8{prdata[23]}})
      else $error("result not sign extended");
   a_ready_clear: assert property (@(posedge clk_sys) disable iff (srst)
      $rose(conv_ready_n) |-> rd_age_q <= 3'h3)
      else $error("ready released without data read");
   a_mclk_early: assert property (@(posedge clk_sys) disable iff (srst)
      mclk_seen_q && modulator_clk != mclk_prev_q
      |-> mclk_cnt_q == HALF_DIV - 1)
      else $error("modulator clock edge early");
   a_mclk_late: assert property (@(posedge clk_sys) disable iff (srst)
      mclk_seen_q |-> mclk_cnt_q <= HALF_DIV - 1)
      else $error("modulator clock edge late");
endmodule : acfp_checker

bind adcflt_top acfp_checker #(
   .HALF_DIV (HALF_DIV)
) u_acfp_checker (
   .clk_sys       (clk_sys),
   .srst          (srst),
   .paddr         (paddr),
   .psel          (psel),
   .penable       (penable),
   .pwrite        (pwrite),
   .pwdata        (pwdata),
   .pstrb         (pstrb),
   .prdata        (prdata),
   .pready        (pready),
   .pslverr       (pslverr),
   .mod_bit_in    (mod_bit_in),
   .modulator_clk (modulator_clk),
   .conv_ready_n  (conv_ready_n)
);
`default_nettype wire

// ==== dv/acfp_mod_model.sv ====
// Purpose: First-order delta-sigma modulators for both channels
// Assumes: Bits change on the falling modulator clock edge
// Notes:   Ones density gives level / full scale, one meaning +full scale
`timescale 1ns/10ps
`default_nettype none
module acfp_mod_model
(
   input  wire logic               modulator_clk,
   input  wire logic signed [23:0] level0,
   input  wire logic signed [23:0] level1,
   output logic             [1:0]  mod_bit_in
);
   localparam int FS = 32'h0080_0000;
   int         integ [2] = '{0, 0};
   logic [1:0] bits_q    = 2'h0;

   assign mod_bit_in = bits_q;

   // Far edge from the sampling one, so bits are stable when taken
   always @(negedge modulator_clk)
   begin
      integ[0] = integ[0] + int'(level0) - (bits_q[0] ? FS : -FS);
      integ[1] = integ[1] + int'(level1) - (bits_q[1] ? FS : -FS);
      bits_q   = {integ[1] >= 0, integ[0] >= 0};
   end
endmodule : acfp_mod_model
`default_nettype wire

// ==== dv/tb_adc_channel_filter_phase.sv ====
// Purpose: Self-checking bench for the two-channel filter block
// Assumes: HALF_DIV of 2, so one modulator tick every four clocks
// Notes:   Results compared within a tolerance of 1/32 full scale
`timescale 1ns/10ps
`default_nettype none
module tb_adc_channel_filter_phase;
   import adcflt_pkg::*;
   localparam int          HDIV = 2;
   localparam int          TOL  = 32'h0004_0000;
   localparam logic        RD   = 1'b0;
   localparam logic        WR   = 1'b1;
   localparam logic [31:0] L0   = 32'h0020_0000;
   localparam logic [31:0] L1   = 32'hffd0_0000;
   localparam logic [31:0] TP   = 32'h0011_1111;
   localparam logic [31:0] TN   = 32'hffee_eeef;
   localparam logic [31:0] ZR   = 32'h0000_0000;
   typedef struct packed {
      logic [7:0] a; logic w; logic [3:0] s;
      logic [31:0] d; logic [31:0] x; logic e;
   } acfp_reg_row_t;
   typedef struct packed {
      logic [3:0] osr; logic [3:0] hpc; adcflt_insel_t sel; logic dis1;
      logic [31:0] x0; logic [31:0] x1; logic [7:0] n;
   } acfp_flt_row_t;

   acfp_reg_row_t regs [15] = '{
      '{OFS_CTRL, RD, 4'h0, ZR, 32'h0000_0004, 1'b0},
      '{OFS_CH1_CFG, RD, 4'h0, ZR, ZR, 1'b0},
      '{OFS_CTRL, WR, 4'hf, 32'h0000_0001, ZR, 1'b0},
      '{OFS_CH0_CFG, WR, 4'hf, 32'h0000_0064, ZR, 1'b0},
      '{OFS_CH1_CFG, WR, 4'hf, 32'h0000_039c, ZR, 1'b0},
      '{OFS_EFF_PHASE, RD, 4'h0, ZR, 32'h03c0_003f, 1'b0},
      '{OFS_CH0_CFG, WR, 4'h1, 32'hffff_ff1f, ZR, 1'b0},
      '{OFS_CH0_CFG, RD, 4'h0, ZR, 32'h0000_001f, 1'b0},
      '{OFS_CTRL, WR, 4'hf, 32'h0000_0008, ZR, 1'b0},
      '{OFS_EFF_PHASE, RD, 4'h0, ZR, 32'h039c_001f, 1'b0},
      '{OFS_CH0_CFG, WR, 4'hf, 32'h0000_0200, ZR, 1'b0},
      '{OFS_CTRL, WR, 4'hf, ZR, ZR, 1'b0},
      '{OFS_EFF_PHASE, RD, 4'h0, ZR, 32'h03e0_03e0, 1'b0},
      '{8'h1c, RD, 4'h0, ZR, ZR, 1'b1},
      '{8'h20, WR, 4'hf, 32'h1234_5678, ZR, 1'b1}};
   acfp_flt_row_t flt [7] = '{
      '{4'h0, 4'h0, SEL_NORMAL, 1'b0, L0, L1, 8'h05},
      '{4'h0, 4'h0, SEL_SHORT, 1'b0, ZR, ZR, 8'h05},
      '{4'h0, 4'h0, SEL_TEST_POS, 1'b0, TP, TP, 8'h05},
      '{4'h0, 4'h0, SEL_TEST_NEG, 1'b0, TN, TN, 8'h05},
      '{4'h5, 4'h0, SEL_NORMAL, 1'b0, L0, L1, 8'h04},
      '{4'h0, 4'hf, SEL_NORMAL, 1'b1, L0, L1, 8'h06},
      '{4'h0, 4'h1, SEL_NORMAL, 1'b1, ZR, L1, 8'h18}};

   logic              clk_sys;
   logic              srst     = 1'b1;
   logic [7:0]        paddr    = 8'h00;
   logic              psel     = 1'b0;
   logic              penable  = 1'b0;
   logic              pwrite   = 1'b0;
   logic [31:0]       pwdata   = 32'h0;
   logic [3:0]        pstrb    = 4'h0;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic [1:0]        mod_bit_in;
   logic              modulator_clk;
   logic              conv_ready_n;
   logic signed [23:0] level0  = 24'h20_0000;
   logic signed [23:0] level1  = 24'hd0_0000;
   int                err_total       = 0;
   int                samples_checked = 0;
   int                cyc             = 0;
   int                t0;
   int                t1;
   logic [31:0]       r;
   logic [31:0]       d0;
   logic [31:0]       d1;
   logic              e;

   adcflt_top #(.HALF_DIV (HDIV)) u_adcflt_top (
      .clk_sys (clk_sys), .srst (srst), .paddr (paddr), .psel (psel),
      .penable (penable), .pwrite (pwrite), .pwdata (pwdata),
      .pstrb (pstrb), .prdata (prdata), .pready (pready),
      .pslverr (pslverr), .mod_bit_in (mod_bit_in),
      .modulator_clk (modulator_clk), .conv_ready_n (conv_ready_n));
   acfp_mod_model u_acfp_mod_model (
      .modulator_clk (modulator_clk), .level0 (level0), .level1 (level1),
      .mod_bit_in (mod_bit_in));

   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) cyc <= cyc + 1;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic near(input logic [31:0] got, input logic [31:0] exp);
      int d;
      d = $signed(got) - $signed(exp);
      samples_checked++;
      if ((^got === 1'bx) || d > TOL || d < -TOL)
      begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : near

   task automatic apb(input logic [7:0] a, input logic w,
                      input logic [3:0] s, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
         @(posedge clk_sys);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Reading the second channel hands the result pair back
   task automatic wait_res(output int t, output logic [31:0] a0,
                           output logic [31:0] a1);
      int n;
      logic x;
      for (n = 0; n < 20000 && conv_ready_n !== 1'b0; n++)
         @(posedge clk_sys);
      if (n >= 20000)
      begin
         chk(32'h0000_0000, 32'h0000_0001);
         wrap_up();
      end
      t = cyc;
      apb(OFS_CH0_DATA, RD, 4'h0, ZR, a0, x);
      apb(OFS_CH1_DATA, RD, 4'h0, ZR, a1, x);
      repeat (2) @(posedge clk_sys);
   endtask : wait_res

   task automatic wrap_up;
      $display("checks=%0d mismatches=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up

   initial
   begin
      repeat (60000) @(posedge clk_sys);
      chk(32'h0000_0000, 32'h0000_0001);
      wrap_up();
   end

   initial
   begin
      repeat (8) @(posedge clk_sys);
      srst <= 1'b0;
      @(negedge clk_sys);
      chk({31'h0, conv_ready_n}, 32'h0000_0001);
      foreach (regs[i])
      begin
         apb(regs[i].a, regs[i].w, regs[i].s, regs[i].d, r, e);
         if (regs[i].w == RD)
            chk(r, regs[i].x);
         chk({31'h0, e}, {31'h0, regs[i].e});
      end
      foreach (flt[i])
      begin
         apb(OFS_CH0_CFG, WR, 4'hf, {14'h0, flt[i].sel, 16'h0}, r, e);
         apb(OFS_CH1_CFG, WR, 4'hf,
             {11'h0, flt[i].dis1, 2'h0, flt[i].sel, 16'h0}, r, e);
         apb(OFS_CTRL, WR, 4'hf, {24'h0, flt[i].hpc, flt[i].osr}, r, e);
         repeat (flt[i].n) wait_res(t0, d0, d1);
         near(d0, flt[i].x0);
         near(d1, flt[i].x1);
      end
      // Ready timing follows the later of the two windows
      apb(OFS_CH1_CFG, WR, 4'hf, ZR, r, e);
      apb(OFS_CTRL, WR, 4'hf, ZR, r, e);
      repeat (3) wait_res(t0, d0, d1);
      apb(OFS_CH1_CFG, WR, 4'hf, 32'h0000_0010, r, e);
      repeat (3) wait_res(t1, d0, d1);
      chk(32'((t1 - t0) % (128 * HDIV)), 32'(32 * HDIV));
      srst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      @(negedge clk_sys);
      chk({31'h0, conv_ready_n}, 32'h0000_0001);
      wrap_up();
   end
endmodule : tb_adc_channel_filter_phase
`default_nettype wire
